// >>> logic/mmr_top.sv
// Address decoder for the core's memory spaces, extended RAM banks and
// reset source combiner. Assumes pins arrive asynchronously; core strobes
// and timer overflows come from logic on clk.
//
// Contract
// RULE1: Lowest 32 bytes map to four register banks
// RULE2: Bit area 20H-2FH addressable per bit
// RULE3: User RAM 30H-7FH byte access only
// RULE4: Direct upper half selects special function area
// RULE5: Indirect upper half reaches bank A
// RULE6: Indirect top quarter reaches bank B
// RULE7: One bank; 96H selects A, 69H B
// RULE8: Bank A lost in standby, B kept
// RULE9: Software keeps stack within 08H-BFH
// RULE10: Code below 1000H boot ROM, else flash
// RULE11: External data decodes to 4K on-chip RAM
// RULE12: Software leaves system ONCHIP_EXTERNAL_DATA_RAM area alone
// RULE13: Page 0D00H is sampling receive buffer
// RULE14: Register-pointer moves reach lowest 256 bytes only
// RULE15: Only timer 0/1 interrupts, own vectors
// RULE16: Only normal and standby modes
// RULE17: Four reset sources; three also wake
// RULE18: Reset pin low 10 ms resets
// RULE19: Standby key low long enough resets
// RULE20: Normal mode key lows never reset
// RULE21: Low-voltage hold below 1.85V, release above 1.95V
// RULE22: Watchdog 20-bit overflow resets; software clears
// RULE23: Bank select resets to bank A
// RULE24: Internal reset ORs sources, synchronised
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
module mmr_top
  import mmr_pkg::*;
#(
  parameter int EXT_CYC = EXT_HOLD_CYC,
  parameter int KEY_CYC = KEY_HOLD_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        core_req,
  input  wire mmr_kind_t   core_kind,
  input  wire logic [15:0] core_addr,
  input  wire logic        core_we,
  input  wire logic [7:0]  core_wdata,
  output logic             map_valid_r,
  output mmr_region_t      map_region_r,
  output logic [15:0]      map_addr_r,
  output logic [2:0]       map_bit_r,
  output logic [7:0]       ext_rdata_r,
  input  wire logic        timer0_ovf,
  input  wire logic        timer1_ovf,
  output logic             irq_req_r,
  output logic [15:0]      irq_vector_r,
  input  wire logic        external_reset_pin_n,
  input  wire logic [7:0]  keyboard_inputs,
  input  wire logic        low_voltage_detector_trip,
  input  wire logic        low_voltage_detector_clear,
  output logic             standby_r,
  output logic             bank_a_power_r,
  output logic             core_rst_n_r
);
  // ******************************
  // Declarations
  // ******************************
  logic [7:0]        bank_r;
  logic              wait_r;
  logic [31:0]       rdata_r;
  logic [3:0]        cause_r;
  logic [2:0]        pin_s1, pin_s2;
  logic [7:0]        key_s1, key_s2;
  logic [CNT_W-1:0]  ext_cnt_r, key_cnt_r;
  logic              ext_act_r, key_act_r, lvd_hold_r, wdt_fire_r, int_rst_r;
  logic [WDT_W-1:0]  wdt_cnt_r;
  logic [7:0]        bank_a_mem [128];
  logic [7:0]        bank_b_mem [64];
  logic [127:0]      a_valid_r;
  logic              acc;
  logic              wr_hit;
  mmr_region_t       reg_nxt;
  logic [15:0]       addr_nxt;
  logic [2:0]        bit_nxt;

  assign acc    = (avs_read | avs_write) & wait_r;
  assign wr_hit = avs_write & !wait_r;  // Writes land on the answering edge only

  // ******************************
  // Avalon slave
  // ******************************
  // One wait cycle, then a single low cycle answers the request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r <= !acc;
      if (acc && avs_read) begin
        case (avs_address)
          OFS_BANK:   rdata_r <= {24'h0, bank_r};
          OFS_MODE:   rdata_r <= {31'h0, standby_r};
          OFS_STATUS: rdata_r <= {24'h0, cause_r, 1'b0, lvd_hold_r, standby_r, bank_r == BANK_B_SEL};
          default:    rdata_r <= 32'h0;
        endcase
      end
    end
  end
  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;

  // Bank select; other values are ignored so a stray write cannot leave both off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_r <= BANK_RST;
    end else if (int_rst_r) begin
      bank_r <= BANK_RST;  // RULE23
    end else if (wr_hit && avs_address == OFS_BANK &&
                 (avs_writedata[7:0] == BANK_A_SEL || avs_writedata[7:0] == BANK_B_SEL)) begin
      bank_r <= avs_writedata[7:0];  // RULE7
    end
  end

  // Mode: bit 0 enters standby; only a waking reset leaves it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      standby_r      <= 1'b0;
      bank_a_power_r <= 1'b1;
    end else if (int_rst_r) begin
      standby_r      <= 1'b0;  // RULE16
      bank_a_power_r <= 1'b1;
    end else if (wr_hit && avs_address == OFS_MODE && avs_writedata[0]) begin
      standby_r      <= 1'b1;  // RULE16
      bank_a_power_r <= 1'b0;  // RULE8
    end
  end

  // Sticky reset causes; a new cause beats a write-one-to-clear
  // Kept through the internal reset so software can see why it restarted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_r <= 4'h0;
    end else begin
      cause_r <= (cause_r & ~((wr_hit && avs_address == OFS_STATUS) ? avs_writedata[7:4] : 4'h0))
               | {wdt_fire_r, lvd_hold_r, key_act_r, ext_act_r};
    end
  end

  // ******************************
  // Address decode
  // ******************************
  // Region and local address per access kind
  always_comb begin
    reg_nxt  = R_NONE;
    addr_nxt = 16'h0;
    bit_nxt  = 3'h0;
    case (core_kind)
      K_DIRECT: begin
        addr_nxt = {8'h00, core_addr[7:0]};
        if (core_addr[7:0] >= UPPER_BASE) begin
          reg_nxt = R_SFA;  // RULE4
        end else if (core_addr[7:0] >= USER_BASE) begin
          reg_nxt = R_USERRAM;  // RULE3
        end else if (core_addr[7:0] >= BIT_BASE) begin
          reg_nxt = R_BITAREA;
        end else begin
          reg_nxt = R_WORKREG;  // RULE1
        end
      end
      K_INDIRECT: begin
        if (core_addr[7:0] < UPPER_BASE) begin
          addr_nxt = {8'h00, core_addr[7:0]};
          reg_nxt  = core_addr[7:0] >= USER_BASE ? R_USERRAM :
                     core_addr[7:0] >= BIT_BASE ? R_BITAREA : R_WORKREG;
        end else if (core_addr[7:0] >= SHARE_BASE && bank_r == BANK_B_SEL) begin
          addr_nxt = {10'h0, core_addr[5:0]};
          reg_nxt  = R_BANK_B;  // RULE6
        end else begin
          addr_nxt = {9'h0, core_addr[6:0]};
          reg_nxt  = R_BANK_A;  // RULE5
        end
      end
      K_BIT: begin
        bit_nxt = core_addr[2:0];
        if (core_addr[7]) begin
          addr_nxt = {8'h00, core_addr[7:3], 3'h0};
          reg_nxt  = R_SFA;
        end else begin
          addr_nxt = {8'h00, BIT_BASE[7:4], core_addr[6:3]};  // RULE2
          reg_nxt  = R_BITAREA;  // RULE2
        end
      end
      K_CODE: begin
        addr_nxt = core_addr;
        reg_nxt  = core_addr < FLASH_BASE ? R_BOOTROM : R_FLASH;  // RULE10
      end
      K_XDPTR, K_XRI: begin
        addr_nxt = core_kind == K_XRI ? {8'h00, core_addr[7:0]} : core_addr;  // RULE14
        if (addr_nxt >= FLASH_BASE) begin
          reg_nxt = R_NONE;  // RULE11
        end else if (addr_nxt[15:8] == XSAMP_PAGE) begin
          reg_nxt = R_ONCHIP_EXTERNAL_DATA_RAM_SAMPLE;  // RULE13
        end else if (addr_nxt >= XSYS_LO && addr_nxt <= XSYS_HI) begin
          reg_nxt = R_ONCHIP_EXTERNAL_DATA_RAM_SYS;
        end else begin
          reg_nxt = R_ONCHIP_EXTERNAL_DATA_RAM;  // RULE11
        end
      end
      default: reg_nxt = R_NONE;
    endcase
  end

  // Decode result registered so every output comes from a flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      map_valid_r  <= 1'b0;
      map_region_r <= R_NONE;
      map_addr_r   <= 16'h0;
      map_bit_r    <= 3'h0;
    end else begin
      map_valid_r  <= core_req;
      map_region_r <= core_req ? reg_nxt : R_NONE;
      map_addr_r   <= addr_nxt;
      map_bit_r    <= bit_nxt;
    end
  end

  // ******************************
  // Extended RAM banks
  // ******************************
  // Arrays have no reset: bank B content survives standby and reset
  always_ff @(posedge clk) begin
    if (core_req && core_we && reg_nxt == R_BANK_A) begin
      bank_a_mem[addr_nxt[6:0]] <= core_wdata;
    end
    if (core_req && core_we && reg_nxt == R_BANK_B) begin
      bank_b_mem[addr_nxt[5:0]] <= core_wdata;  // RULE8
    end
  end

  // Bank A entries read as zero until rewritten after a standby
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_valid_r   <= 128'h0;
      ext_rdata_r <= 8'h00;
    end else begin
      if (standby_r) begin
        a_valid_r <= 128'h0;  // RULE8
      end else if (core_req && core_we && reg_nxt == R_BANK_A) begin
        a_valid_r[addr_nxt[6:0]] <= 1'b1;
      end
      if (core_req && reg_nxt == R_BANK_A) begin
        ext_rdata_r <= a_valid_r[addr_nxt[6:0]] ? bank_a_mem[addr_nxt[6:0]] : 8'h00;
      end else if (core_req && reg_nxt == R_BANK_B) begin
        ext_rdata_r <= bank_b_mem[addr_nxt[5:0]];
      end
    end
  end

  // ******************************
  // Interrupts
  // ******************************
  // Timer 0 wins a tie; no other source exists
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req_r    <= 1'b0;
      irq_vector_r <= 16'h0;
    end else begin
      irq_req_r    <= !int_rst_r && (timer0_ovf || timer1_ovf);  // RULE15
      irq_vector_r <= timer0_ovf ? VEC_T0 : VEC_T1;  // RULE15
    end
  end

  // ******************************
  // Reset sources
  // ******************************
  // Two-flop synchronisers for every pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= 3'b100;
      pin_s2 <= 3'b100;
      key_s1 <= 8'hff;
      key_s2 <= 8'hff;
    end else begin
      pin_s1 <= {external_reset_pin_n, low_voltage_detector_trip, low_voltage_detector_clear};
      pin_s2 <= pin_s1;
      key_s1 <= keyboard_inputs;
      key_s2 <= key_s1;
    end
  end

  // External pin: reset only after a continuous low of the hold time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_cnt_r <= '0;
      ext_act_r <= 1'b0;
    end else if (pin_s2[2]) begin
      ext_cnt_r <= '0;
      ext_act_r <= 1'b0;
    end else if (ext_cnt_r == CNT_W'(EXT_CYC - 1)) begin
      ext_act_r <= 1'b1;  // RULE18
    end else begin
      ext_cnt_r <= ext_cnt_r + 1'b1;
    end
  end

  // Keys reset only from standby; the wake clears standby and ends it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_cnt_r <= '0;
      key_act_r <= 1'b0;
    end else if (!standby_r || &key_s2) begin
      key_cnt_r <= '0;  // RULE20
      key_act_r <= 1'b0;
    end else if (key_cnt_r == CNT_W'(KEY_CYC - 1)) begin
      key_act_r <= 1'b1;  // RULE19
    end else begin
      key_cnt_r <= key_cnt_r + 1'b1;
    end
  end

  // Detector hysteresis: trip sets, clear releases, trip wins a tie
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvd_hold_r <= 1'b0;
    end else if (pin_s2[1]) begin
      lvd_hold_r <= 1'b1;  // RULE21
    end else if (pin_s2[0]) begin
      lvd_hold_r <= 1'b0;  // RULE21
    end
  end

  // Watchdog halts in standby, so it can never be a wake source
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_cnt_r  <= '0;
      wdt_fire_r <= 1'b0;
    end else if (int_rst_r || (wr_hit && avs_address == OFS_WDTCLR)) begin
      wdt_cnt_r  <= '0;  // RULE22
      wdt_fire_r <= 1'b0;
    end else if (!standby_r) begin
      wdt_cnt_r  <= wdt_cnt_r + 1'b1;
      wdt_fire_r <= &wdt_cnt_r;  // RULE22
    end
  end

  // Combined reset; held until every source has let go
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_rst_r    <= 1'b1;
      core_rst_n_r <= 1'b0;
    end else begin
      int_rst_r    <= ext_act_r | key_act_r | lvd_hold_r | wdt_fire_r;  // RULE17 RULE24
      core_rst_n_r <= !(ext_act_r | key_act_r | lvd_hold_r | wdt_fire_r);  // RULE24
    end
  end

  // ******************************
  // Assertions
  // ******************************
  a_bank_reset: assert property (@(posedge clk) disable iff (!arst_n)
    int_rst_r |=> bank_r == BANK_A_SEL) else $error("bank not A after reset"); // RULE23
  a_bank_select: assert property (@(posedge clk) disable iff (!arst_n)
    wr_hit && avs_address == OFS_BANK && avs_writedata[7:0] == BANK_B_SEL && !int_rst_r
    |=> bank_r == BANK_B_SEL) else $error("bank B not selected"); // RULE7
  a_direct_upper: assert property (@(posedge clk) disable iff (!arst_n)
    core_req && core_kind == K_DIRECT && core_addr[7] |=> map_region_r == R_SFA)
    else $error("direct upper not special area"); // RULE4
  a_bit_byte: assert property (@(posedge clk) disable iff (!arst_n)
    core_req && core_kind == K_BIT && !core_addr[7]
    |=> map_addr_r[7:0] == 8'h20 + {5'h0, $past(core_addr[6:3])} && map_bit_r == $past(core_addr[2:0]))
    else $error("bit address wrong"); // RULE2
  a_ri_page: assert property (@(posedge clk) disable iff (!arst_n)
    core_req && core_kind == K_XRI |=> map_addr_r[15:8] == 8'h00 && map_region_r != R_NONE)
    else $error("pointer move left low page"); // RULE14
  a_code_split: assert property (@(posedge clk) disable iff (!arst_n)
    core_req && core_kind == K_CODE
    |=> map_region_r == ($past(core_addr) < 16'h1000 ? R_BOOTROM : R_FLASH))
    else $error("code region wrong"); // RULE10
  a_key_normal: assert property (@(posedge clk) disable iff (!arst_n)
    !standby_r |=> !key_act_r) else $error("key reset in normal mode"); // RULE20
  a_wdt_reset: assert property (@(posedge clk) disable iff (!arst_n)
    wdt_fire_r |=> int_rst_r ##1 !standby_r) else $error("watchdog did not reset"); // RULE22
  a_lvd_hold: assert property (@(posedge clk) disable iff (!arst_n)
    pin_s2[1] |=> lvd_hold_r ##1 !core_rst_n_r) else $error("low voltage not held"); // RULE21
  a_ext_filter: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(ext_act_r) |-> ext_cnt_r == CNT_W'(EXT_CYC - 1) && !$past(pin_s2[2]))
    else $error("pin reset too early"); // RULE18

  c_key_wake: cover property (@(posedge clk) disable iff (!arst_n) standby_r && key_act_r);
  c_wdt_fire: cover property (@(posedge clk) disable iff (!arst_n) wdt_fire_r);
  c_bank_b: cover property (@(posedge clk) disable iff (!arst_n) map_region_r == R_BANK_B);
endmodule : mmr_top

// >>> logic/mmr_pkg.sv
// Constants and types for the memory map decoder and reset combiner.
// Assumes a single 25 MHz system clock shared by core and bus.
package mmr_pkg;
  // ******************************
  // Clock and timing
  // ******************************
  localparam int CLK_HZ      = 25_000_000;
  localparam int EXT_HOLD_MS = 10;
  localparam int KEY_HOLD_US = 1000;
  localparam int EXT_HOLD_CYC = EXT_HOLD_MS * (CLK_HZ / 1000);
  localparam int KEY_HOLD_CYC = (KEY_HOLD_US * (CLK_HZ / 100_000) + 9) / 10;
  localparam int CNT_W       = 18;
  localparam int WDT_W       = 20;

  // ******************************
  // Register map (byte offsets)
  // ******************************
  localparam logic [4:0] OFS_BANK   = 5'h00;
  localparam logic [4:0] OFS_MODE   = 5'h04;
  localparam logic [4:0] OFS_WDTCLR = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [7:0] BANK_A_SEL = 8'h96;
  localparam logic [7:0] BANK_B_SEL = 8'h69;
  localparam logic [7:0] BANK_RST   = 8'h96;
  localparam int         ST_CAUSE   = 4;

  // ******************************
  // Address boundaries
  // ******************************
  localparam logic [7:0]  BIT_BASE   = 8'h20;
  localparam logic [7:0]  USER_BASE  = 8'h30;
  localparam logic [7:0]  UPPER_BASE = 8'h80;
  localparam logic [7:0]  SHARE_BASE = 8'hc0;
  localparam logic [15:0] FLASH_BASE = 16'h1000;
  localparam logic [15:0] XSYS_LO    = 16'h0100;
  localparam logic [15:0] XSYS_HI    = 16'h01ed;
  localparam logic [7:0]  XSAMP_PAGE = 8'h0d;

  // Interrupt vectors, arbitrary values
  localparam logic [15:0] VEC_T0 = 16'h1003;
  localparam logic [15:0] VEC_T1 = 16'h100b;

  typedef enum logic [2:0] {
    K_DIRECT, K_INDIRECT, K_BIT, K_CODE, K_XDPTR, K_XRI
  } mmr_kind_t;

  typedef enum logic [3:0] {
    R_NONE, R_WORKREG, R_BITAREA, R_USERRAM, R_SFA, R_BANK_A, R_BANK_B,
    R_BOOTROM, R_FLASH, R_ONCHIP_EXTERNAL_DATA_RAM, R_ONCHIP_EXTERNAL_DATA_RAM_SYS, R_ONCHIP_EXTERNAL_DATA_RAM_SAMPLE
  } mmr_region_t;
endpackage : mmr_pkg

// >>> testbench/mmr_core_model.sv
// Behavioural model of the core that issues decoded memory accesses.
// Assumes the decoder takes a strobe on a rising edge and answers one cycle later.
module mmr_core_model
  import mmr_pkg::*;
(
  input  wire logic   clk,
  output logic        core_req,
  output mmr_kind_t   core_kind,
  output logic [15:0] core_addr,
  output logic        core_we,
  output logic [7:0]  core_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ******************************
  // Access driver
  // ******************************
  // Idle values from time zero
  initial begin
    core_req   = 1'b0;
    core_kind  = K_DIRECT;
    core_addr  = 16'h0000;
    core_we    = 1'b0;
    core_wdata = 8'h00;
  end

  // One-cycle strobe; afterwards address and data go stale on purpose so that
  // nothing downstream can lean on a value the core no longer presents
  task automatic access(input mmr_kind_t k, input logic [15:0] a, input logic w, input logic [7:0] d);
    core_req   <= 1'b1;
    core_kind  <= k;
    core_addr  <= a;
    core_we    <= w;
    core_wdata <= d;
    @(posedge clk);
    core_req   <= 1'b0;
    core_we    <= 1'b0;
    core_addr  <= ~a;
    core_wdata <= ~d;
    @(posedge clk);
  endtask : access
endmodule : mmr_core_model

// >>> testbench/tb_memory_map_and_reset_sources.sv
// Self-checking bench for the memory map decoder and reset combiner.
// Assumes a 25 MHz clock and shortened hold counts for pin and key resets.
module tb_memory_map_and_reset_sources
  import mmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EXT_N = 8;
  localparam int KEY_N = 4;

  logic        clk, arst_n, avs_read, avs_write, avs_waitrequest, core_req, core_we;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  mmr_kind_t   core_kind;
  mmr_region_t map_region_r;
  logic [15:0] core_addr, map_addr_r, irq_vector_r;
  logic [7:0]  core_wdata, ext_rdata_r, keyboard_inputs;
  logic [2:0]  map_bit_r;
  logic        map_valid_r, irq_req_r, timer0_ovf, timer1_ovf, external_reset_pin_n, seen_rst;
  logic        low_voltage_detector_trip, low_voltage_detector_clear, standby_r, bank_a_power_r, core_rst_n_r;
  int          mismatches, total_checks;

  // Decode rows: kind, address, region, local address, bit position
  logic [41:0] rows [22] = '{
    {K_DIRECT, 16'h0000, R_WORKREG, 16'h0000, 3'h0}, {K_DIRECT, 16'h001f, R_WORKREG, 16'h001f, 3'h0},
    {K_DIRECT, 16'h0020, R_BITAREA, 16'h0020, 3'h0}, {K_DIRECT, 16'h002f, R_BITAREA, 16'h002f, 3'h0},
    {K_DIRECT, 16'h0030, R_USERRAM, 16'h0030, 3'h0}, {K_DIRECT, 16'h007f, R_USERRAM, 16'h007f, 3'h0},
    {K_DIRECT, 16'h0080, R_SFA, 16'h0080, 3'h0},     {K_DIRECT, 16'h00ff, R_SFA, 16'h00ff, 3'h0},
    {K_BIT, 16'h0000, R_BITAREA, 16'h0020, 3'h0},    {K_BIT, 16'h007f, R_BITAREA, 16'h002f, 3'h7},
    {K_BIT, 16'h008b, R_SFA, 16'h0088, 3'h3},        {K_INDIRECT, 16'h0080, R_BANK_A, 16'h0000, 3'h0},
    {K_CODE, 16'h0fff, R_BOOTROM, 16'h0000, 3'h0},   {K_CODE, 16'h1000, R_FLASH, 16'h0000, 3'h0},
    {K_XDPTR, 16'h0fff, R_ONCHIP_EXTERNAL_DATA_RAM, 16'h0000, 3'h0},     {K_XDPTR, 16'h1000, R_NONE, 16'h0000, 3'h0},
    {K_XDPTR, 16'h0100, R_ONCHIP_EXTERNAL_DATA_RAM_SYS, 16'h0000, 3'h0}, {K_XDPTR, 16'h01ee, R_ONCHIP_EXTERNAL_DATA_RAM, 16'h0000, 3'h0},
    {K_XDPTR, 16'h0d00, R_ONCHIP_EXTERNAL_DATA_RAM_SAMPLE, 16'h0, 3'h0}, {K_XDPTR, 16'h0dff, R_ONCHIP_EXTERNAL_DATA_RAM_SAMPLE, 16'h0, 3'h0},
    {K_XRI, 16'h0d05, R_ONCHIP_EXTERNAL_DATA_RAM, 16'h0000, 3'h0},       {K_XRI, 16'h01ed, R_ONCHIP_EXTERNAL_DATA_RAM, 16'h0000, 3'h0}
  };

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  mmr_top #(.EXT_CYC(EXT_N), .KEY_CYC(KEY_N)) dut (
    .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .core_req, .core_kind, .core_addr, .core_we, .core_wdata, .map_valid_r,
    .map_region_r, .map_addr_r, .map_bit_r, .ext_rdata_r, .timer0_ovf, .timer1_ovf, .irq_req_r,
    .irq_vector_r, .external_reset_pin_n, .keyboard_inputs, .low_voltage_detector_trip,
    .low_voltage_detector_clear, .standby_r, .bank_a_power_r, .core_rst_n_r
  );
  mmr_core_model u_core (.clk, .core_req, .core_kind, .core_addr, .core_we, .core_wdata);

  // ******************************
  // Shared tasks
  // ******************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // Holds the request until waitrequest is sampled low; one idle edge after
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~w;
    avs_write     <= w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      $display("unexpected at %0t: bus wait ran out", $time);
      mismatches++;
      end_of_test();
    end
    @(posedge clk);
  endtask : bus

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic chkb(input mmr_region_t r, input logic [15:0] a, input logic [7:0] d);
    chk(map_region_r, r);
    chk(map_addr_r, a);
    chk(ext_rdata_r, d);
  endtask : chkb

  // Bounded wait for the combined reset to reach a level
  task automatic wait_rst(input logic lvl);
    int n;
    n = 0;
    while (core_rst_n_r !== lvl && n < 60) begin
      @(posedge clk);
      n++;
    end
    total_checks++;
    if (core_rst_n_r !== lvl) begin
      $display("unexpected at %0t: reset wait ran out", $time);
      mismatches++;
      end_of_test();
    end
  endtask : wait_rst

  // ******************************
  // Main sequence
  // ******************************
  initial begin
    {arst_n, avs_read, avs_write, timer0_ovf, timer1_ovf, low_voltage_detector_trip} = 6'h00;
    {external_reset_pin_n, low_voltage_detector_clear} = 2'h3;
    avs_address     = 5'h00;
    avs_writedata   = 32'h0;
    keyboard_inputs = 8'hff;
    mismatches      = 0;
    total_checks    = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    wait_rst(1'b1);
    chk(standby_r, 1'b0);
    chk(bank_a_power_r, 1'b1);
    rdchk(OFS_BANK, 32'h96);
    bus(1'b1, 5'h10, 32'h69);
    rdchk(OFS_BANK, 32'h96);
    rdchk(5'h10, 32'h0);
    // Table of plain decodes, one access per row
    foreach (rows[i]) begin
      u_core.access(mmr_kind_t'(rows[i][41:39]), rows[i][38:23], 1'b0, 8'h00);
      chk(map_valid_r, 1'b1);
      chk(map_region_r, rows[i][22:19]);
      if (rows[i][41:39] < K_CODE) begin
        chk(map_addr_r, rows[i][18:3]);
      end
      if (rows[i][41:39] == K_BIT) begin
        chk(map_bit_r, rows[i][2:0]);
      end
    end
    // Both banks share C0-FF; only the selected one answers there
    bus(1'b1, OFS_BANK, 32'h69);
    u_core.access(K_INDIRECT, 16'h00c5, 1'b1, 8'h5a);
    u_core.access(K_INDIRECT, 16'h00c5, 1'b0, 8'h00);
    chkb(R_BANK_B, 16'h0005, 8'h5a);
    u_core.access(K_INDIRECT, 16'h0085, 1'b1, 8'h3c);
    u_core.access(K_INDIRECT, 16'h0085, 1'b0, 8'h00);
    chkb(R_BANK_A, 16'h0005, 8'h3c);
    rdchk(OFS_STATUS, 32'h01);
    bus(1'b1, OFS_BANK, 32'h12);
    rdchk(OFS_BANK, 32'h69);
    bus(1'b1, OFS_BANK, 32'h96);
    u_core.access(K_INDIRECT, 16'h00c5, 1'b1, 8'h77);
    u_core.access(K_INDIRECT, 16'h00c5, 1'b0, 8'h00);
    chkb(R_BANK_A, 16'h0045, 8'h77);
    // Standby, then a key wakes the chip through reset
    bus(1'b1, OFS_BANK, 32'h69);
    bus(1'b1, OFS_MODE, 32'h1);
    rdchk(OFS_MODE, 32'h1);
    chk(standby_r, 1'b1);
    chk(bank_a_power_r, 1'b0);
    keyboard_inputs <= 8'hfe;
    wait_rst(1'b0);
    keyboard_inputs <= 8'hff;
    wait_rst(1'b1);
    chk(standby_r, 1'b0);
    rdchk(OFS_BANK, 32'h96);
    rdchk(OFS_STATUS, 32'h20);
    bus(1'b1, OFS_STATUS, 32'hf0);
    rdchk(OFS_STATUS, 32'h0);
    u_core.access(K_INDIRECT, 16'h0085, 1'b0, 8'h00);
    chkb(R_BANK_A, 16'h0005, 8'h00);
    bus(1'b1, OFS_BANK, 32'h69);
    u_core.access(K_INDIRECT, 16'h00c5, 1'b0, 8'h00);
    chkb(R_BANK_B, 16'h0005, 8'h5a);
    // Keys held low while running must be ignored
    seen_rst = 1'b0;
    keyboard_inputs <= 8'h00;
    repeat (30) begin
      @(posedge clk);
      if (core_rst_n_r !== 1'b1) seen_rst = 1'b1;
    end
    keyboard_inputs <= 8'hff;
    chk(seen_rst, 1'b0);
    // External pin: not before the hold count, then reset until released
    external_reset_pin_n <= 1'b0;
    repeat (EXT_N) @(posedge clk);
    chk(core_rst_n_r, 1'b1);
    wait_rst(1'b0);
    external_reset_pin_n <= 1'b1;
    wait_rst(1'b1);
    rdchk(OFS_STATUS, 32'h10);
    bus(1'b1, OFS_STATUS, 32'hf0);
    // Supply dip: held through the band between the two thresholds
    low_voltage_detector_clear <= 1'b0;
    low_voltage_detector_trip  <= 1'b1;
    wait_rst(1'b0);
    low_voltage_detector_trip <= 1'b0;
    repeat (10) @(posedge clk);
    chk(core_rst_n_r, 1'b0);
    low_voltage_detector_clear <= 1'b1;
    wait_rst(1'b1);
    rdchk(OFS_STATUS, 32'h40);
    // Watchdog clear reads back as zero
    bus(1'b1, OFS_WDTCLR, 32'h1);
    rdchk(OFS_WDTCLR, 32'h0);
    // Each timer overflow raises its own vector
    for (int t = 0; t < 2; t++) begin
      timer0_ovf <= (t == 0);
      timer1_ovf <= (t == 1);
      @(posedge clk);
      {timer0_ovf, timer1_ovf} <= 2'h0;
      @(posedge clk);
      chk(irq_req_r, 1'b1);
      chk(irq_vector_r, (t == 0) ? VEC_T0 : VEC_T1);
    end
    end_of_test();
  end
endmodule : tb_memory_map_and_reset_sources
